// ### design/zvs_gate_sequencer.sv
// What this block does
// - High-side gates run a fixed half-duty square wave, unaffected by modulation.
// - Low-side gates end on the trailing edge; their turn-on waits the resonant delay.
// - All gates stay low while supply lockout is active.
// - Peak-limit trip ends gate pulses at once and holds them until next period.
// - Peak-limit trip restarts soft-start from zero, giving hiccup operation.
// - Latch-off input latches the device off; only supply removal clears it.
// - Run request cannot clear the latched-off state.
// - Run request low stops all gates, rectifiers too, and resets soft-start.
// - Low-side turn-on follows high-side turn-off by 4.01 ns per kohm plus 13 ns.
// - Current input blanked after each leading edge, 2 ns per kohm plus 15 ns.
// - Current ramp stays blanked through the resonant delay phase.
// - Edge blanking stays off until soft-start exceeds 400 mV.
// - Edge blanking disabled when the control register's blank-off bit is set.
// - Ramp level-shift and summing circuits reset in every clock dead time.
// - Each rectifier gate turns off one dead time before its high-side gate.
// - Open-drain power-good pulls low while output is in regulation.
// - Power-good enters at -3/+5 percent, leaves outside -5/+3 percent.
// - Bridge switches at half the internal clock rate, legs alternating.
// - Dead time separates low-side turn-off from same-leg high-side turn-on.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "zvs_cfg.svh"

module zvs_gate_sequencer (
    // Clock and reset
    input  wire logic                   CLK_SYS,
    input  wire logic                   RESET,
    // Register port
    input  wire logic [`ZVS_ADDR_W-1:0] REG_ADDR,
    input  wire logic [`ZVS_DATA_W-1:0] REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output logic      [`ZVS_DATA_W-1:0] REG_RDATA,
    // Supply and control inputs
    input  wire logic                   SUPPLY_LOCKOUT,
    input  wire logic                   PEAK_LIMIT_SENSE,
    input  wire logic                   LATCH_OFF_INPUT,
    input  wire logic                   RUN_REQUEST,
    input  wire logic                   CURRENT_TRIP,
    // Feedback window comparators
    input  wire logic                   FB_ABOVE_M3,
    input  wire logic                   FB_ABOVE_M5,
    input  wire logic                   FB_BELOW_P3,
    input  wire logic                   FB_BELOW_P5,
    // Gate outputs
    output logic                        HIGH_SIDE_GATE_A,
    output logic                        HIGH_SIDE_GATE_B,
    output logic                        LOW_SIDE_GATE_A,
    output logic                        LOW_SIDE_GATE_B,
    output logic                        RECTIFIER_GATE_A,
    output logic                        RECTIFIER_GATE_B,
    // Analog front-end controls
    output logic                        RAMP_RESET,
    output logic                        EDGE_BLANKING,
    output logic      [`ZVS_SS_W-1:0]   SOFT_START_LEVEL,
    // Open-drain power-good pin
    input  wire logic                   POWER_GOOD_FLAG_I,
    output logic                        POWER_GOOD_FLAG_O,
    output logic                        POWER_GOOD_FLAG_OE
);
    function automatic logic [7:0] delay_cycles(input logic [7:0] kohm,
                                                input int slope_ps,
                                                input int off_ps);
        int t;
        t = slope_ps * int'(kohm) + off_ps + `ZVS_CLK_PS - 1;
        delay_cycles = 8'(t / `ZVS_CLK_PS);
    endfunction

    zvs_pkg::zvs_state_e state_reg;
    zvs_pkg::zvs_state_e state_next;

    logic [`ZVS_NSYNC-1:0] sync_q;
    logic                  peak_s;
    logic                  latch_s;
    logic                  run_s;
    logic                  pg_good;

    logic                  blank_off_reg;
    logic [7:0]            period_reg;
    logic [7:0]            dead_reg;
    logic [7:0]            resonant_delay_phase_set_reg;
    logic [7:0]            blank_set_reg;
    logic [7:0]            resonant_delay_phase_cyc;
    logic [7:0]            leb_cyc;

    logic [7:0]            cnt_reg;
    logic                  phase_reg;
    logic                  period_end;
    logic                  in_dead;
    logic                  resonant_delay_phase;
    logic                  enabled;

    logic                  trip_hold_reg;
    logic                  term_reg;
    logic                  low_on_reg;
    logic [7:0]            leb_cnt_reg;
    logic                  leb_armed;
    logic                  blank_any;
    logic                  pwm_stop;

    logic [7:0]            ss_div_reg;
    logic                  ss_tick;
    logic [`ZVS_SS_W-1:0]  ss_reg;

    logic                  ua_reg;
    logic                  ub_reg;
    logic                  la_reg;
    logic                  lb_reg;
    logic                  ra_reg;
    logic                  rb_reg;
    logic                  force_low;

    // Comparator synchronisation
    zvs_sync u_sync (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .d_in  ({FB_BELOW_P5, FB_BELOW_P3, FB_ABOVE_M5, FB_ABOVE_M3,
                 RUN_REQUEST, LATCH_OFF_INPUT, PEAK_LIMIT_SENSE}),
        .q_out (sync_q)
    );

    assign peak_s  = sync_q[0];
    assign latch_s = sync_q[1];
    assign run_s   = sync_q[2];

    zvs_pgood u_pgood (
        .clk      (CLK_SYS),
        .rst      (RESET),
        .above_m3 (sync_q[3]),
        .above_m5 (sync_q[4]),
        .below_p3 (sync_q[5]),
        .below_p5 (sync_q[6]),
        .good     (pg_good)
    );

    // Register writes
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            blank_off_reg  <= `ZVS_RST_CTRL;
            period_reg     <= `ZVS_RST_PERIOD;
            dead_reg       <= `ZVS_RST_DEAD;
            resonant_delay_phase_set_reg <= `ZVS_RST_RESONANT_DELAY_PHASE;
            blank_set_reg  <= `ZVS_RST_BLANK;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `ZVS_OFF_CTRL:   blank_off_reg  <= REG_WDATA[`ZVS_CTRL_BLANK_OFF];
                `ZVS_OFF_PERIOD: period_reg     <= REG_WDATA[7:0];
                `ZVS_OFF_DEAD:   dead_reg       <= REG_WDATA[7:0];
                `ZVS_OFF_RESONANT_DELAY_PHASE: resonant_delay_phase_set_reg <= REG_WDATA[7:0];
                `ZVS_OFF_BLANK:  blank_set_reg  <= REG_WDATA[7:0];
                default: ;
            endcase
        end
    end

    // Register reads, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `ZVS_OFF_CTRL:   REG_RDATA <= {15'h0000, blank_off_reg};
                `ZVS_OFF_PERIOD: REG_RDATA <= {8'h00, period_reg};
                `ZVS_OFF_DEAD:   REG_RDATA <= {8'h00, dead_reg};
                `ZVS_OFF_RESONANT_DELAY_PHASE: REG_RDATA <= {8'h00, resonant_delay_phase_set_reg};
                `ZVS_OFF_BLANK:  REG_RDATA <= {8'h00, blank_set_reg};
                `ZVS_OFF_STATUS: REG_RDATA <= {POWER_GOOD_FLAG_I, pg_good, SUPPLY_LOCKOUT,
                                               state_reg == zvs_pkg::ST_LATCHD, ss_reg};
                default:         REG_RDATA <= '0;
            endcase
        end else begin
            REG_RDATA <= '0;
        end
    end

    assign resonant_delay_phase_cyc = delay_cycles(resonant_delay_phase_set_reg, `ZVS_RES_SLOPE_PS,
                                     `ZVS_RES_OFF_PS);
    assign leb_cyc    = delay_cycles(blank_set_reg, `ZVS_LEB_SLOPE_PS,
                                     `ZVS_LEB_OFF_PS);

    // Operating state; the latch leaves only through lockout or reset
    always_comb begin
        case (state_reg)
            zvs_pkg::ST_IDLE:   state_next = run_s ? zvs_pkg::ST_RUN : zvs_pkg::ST_IDLE;
            zvs_pkg::ST_RUN:    state_next = run_s ? zvs_pkg::ST_RUN : zvs_pkg::ST_IDLE;
            zvs_pkg::ST_LATCHD: state_next = zvs_pkg::ST_LATCHD;
            default:            state_next = zvs_pkg::ST_IDLE;
        endcase
        if (latch_s)
            state_next = zvs_pkg::ST_LATCHD;
        if (SUPPLY_LOCKOUT)
            state_next = zvs_pkg::ST_IDLE;
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET)
            state_reg <= zvs_pkg::ST_IDLE;
        else
            state_reg <= state_next;
    end

    assign enabled = (state_reg == zvs_pkg::ST_RUN) && !SUPPLY_LOCKOUT;

    // Internal clock: one period per leg, legs alternate each period
    assign period_end = (cnt_reg >= period_reg - 8'h01);
    assign in_dead    = (cnt_reg >= period_reg - dead_reg);
    assign resonant_delay_phase = (cnt_reg < resonant_delay_phase_cyc);

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cnt_reg   <= 8'h00;
            phase_reg <= 1'b0;
        end else if (period_end) begin
            cnt_reg   <= 8'h00;
            phase_reg <= !phase_reg;
        end else begin
            cnt_reg   <= cnt_reg + 8'h01;
        end
    end

    // Peak trip hold until the next period; a trip at the boundary is kept
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET)
            trip_hold_reg <= 1'b0;
        else if (peak_s)
            trip_hold_reg <= 1'b1;
        else if (period_end)
            trip_hold_reg <= 1'b0;
    end

    // Blanking of the current comparator
    assign leb_armed = (ss_reg > `ZVS_SS_W'(`ZVS_SS_LEB_CNT)) && !blank_off_reg;
    assign blank_any = resonant_delay_phase
                     || (leb_armed && leb_cnt_reg != 8'h00);
    assign pwm_stop  = CURRENT_TRIP && !blank_any;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET)
            leb_cnt_reg <= 8'h00;
        else if (!low_on_reg && cnt_reg == resonant_delay_phase_cyc - 8'h01)
            leb_cnt_reg <= leb_cyc;
        else if (leb_cnt_reg != 8'h00)
            leb_cnt_reg <= leb_cnt_reg - 8'h01;
    end

    // Low-side pulse decided one count early: the gate register adds a cycle
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            low_on_reg <= 1'b0;
            term_reg   <= 1'b0;
        end else if (period_end || !enabled) begin
            low_on_reg <= 1'b0;
            term_reg   <= 1'b0;
        end else if (peak_s || trip_hold_reg || (low_on_reg && pwm_stop)
                     || cnt_reg >= period_reg - dead_reg - 8'h01) begin
            low_on_reg <= 1'b0;
            term_reg   <= 1'b1;
        end else if (!term_reg && cnt_reg == resonant_delay_phase_cyc - 8'h01) begin
            low_on_reg <= 1'b1;
        end
    end

    // Soft-start ramp with its own step divider
    assign ss_tick = (ss_div_reg == `ZVS_SS_DIV - 8'h01);

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET)
            ss_div_reg <= 8'h00;
        else if (ss_tick || !enabled || peak_s)
            ss_div_reg <= 8'h00;
        else
            ss_div_reg <= ss_div_reg + 8'h01;
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET)
            ss_reg <= '0;
        else if (!enabled || peak_s)
            ss_reg <= '0;
        else if (ss_tick && ss_reg != '1)
            ss_reg <= ss_reg + `ZVS_SS_W'(1);
    end

    // Registered gate drive
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ua_reg <= 1'b0;
            ub_reg <= 1'b0;
            la_reg <= 1'b0;
            lb_reg <= 1'b0;
            ra_reg <= 1'b0;
            rb_reg <= 1'b0;
        end else begin
            ua_reg <= enabled && !trip_hold_reg && !peak_s && !phase_reg;
            ub_reg <= enabled && !trip_hold_reg && !peak_s && phase_reg;
            la_reg <= enabled && low_on_reg && phase_reg;
            lb_reg <= enabled && low_on_reg && !phase_reg;
            ra_reg <= enabled && !trip_hold_reg && !peak_s && !phase_reg
                      && !in_dead;
            rb_reg <= enabled && !trip_hold_reg && !peak_s && phase_reg
                      && !in_dead;
        end
    end

    assign force_low = PEAK_LIMIT_SENSE || SUPPLY_LOCKOUT;

    assign HIGH_SIDE_GATE_A = ua_reg && !force_low;
    assign HIGH_SIDE_GATE_B = ub_reg && !force_low;
    assign LOW_SIDE_GATE_A  = la_reg && !force_low;
    assign LOW_SIDE_GATE_B  = lb_reg && !force_low;
    assign RECTIFIER_GATE_A = ra_reg && !force_low;
    assign RECTIFIER_GATE_B = rb_reg && !force_low;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            RAMP_RESET    <= 1'b1;
            EDGE_BLANKING <= 1'b0;
        end else begin
            RAMP_RESET    <= in_dead;
            EDGE_BLANKING <= blank_any;
        end
    end

    assign SOFT_START_LEVEL   = ss_reg;
    assign POWER_GOOD_FLAG_O  = 1'b0;
    assign POWER_GOOD_FLAG_OE = pg_good;

    // Checks
    sequence s_peak_seen;
        peak_s && !period_end;
    endsequence

    sequence s_gates_idle;
        !ua_reg && !ub_reg && !la_reg && !lb_reg && !ra_reg && !rb_reg;
    endsequence

    a_lockout_low: assert property (@(posedge CLK_SYS) disable iff (RESET)
        SUPPLY_LOCKOUT |-> !HIGH_SIDE_GATE_A && !HIGH_SIDE_GATE_B && !LOW_SIDE_GATE_A
                           && !LOW_SIDE_GATE_B && !RECTIFIER_GATE_A && !RECTIFIER_GATE_B)
        else $error("gate active during lockout");

    a_high_alternate: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !(ua_reg && ub_reg))
        else $error("both high-side gates on");

    a_peak_hold: assert property (@(posedge CLK_SYS) disable iff (RESET)
        s_peak_seen |=> ##1 s_gates_idle)
        else $error("gates not held after peak trip");

    a_ss_restart: assert property (@(posedge CLK_SYS) disable iff (RESET)
        peak_s |=> ss_reg == '0)
        else $error("soft-start not restarted");

    a_latch_holds: assert property (@(posedge CLK_SYS) disable iff (RESET)
        state_reg == zvs_pkg::ST_LATCHD && !SUPPLY_LOCKOUT
        |=> state_reg == zvs_pkg::ST_LATCHD)
        else $error("latch cleared without supply removal");

    a_run_off: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !run_s ##1 !run_s |=> s_gates_idle and ss_reg == '0)
        else $error("outputs active with run low");

    a_resonant_delay_phase_start: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(low_on_reg) |-> $past(cnt_reg) == resonant_delay_phase_cyc - 8'h01)
        else $error("low-side start not at resonant delay");

    a_blank_gate: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ss_reg <= `ZVS_SS_W'(`ZVS_SS_LEB_CNT) && !resonant_delay_phase |-> !blank_any)
        else $error("blanking before soft-start threshold");

    a_rect_early: assert property (@(posedge CLK_SYS) disable iff (RESET)
        in_dead |=> !ra_reg && !rb_reg)
        else $error("rectifier on in dead time");

    a_dead_low: assert property (@(posedge CLK_SYS) disable iff (RESET)
        in_dead && !period_end |=> !la_reg && !lb_reg)
        else $error("low-side on in dead time");
endmodule

// ### design/zvs_cfg.svh
`ifndef ZVS_CFG_SVH
`define ZVS_CFG_SVH

// Register offsets on the plain register port
`define ZVS_ADDR_W        3
`define ZVS_DATA_W        16
`define ZVS_OFF_CTRL      3'h0
`define ZVS_OFF_PERIOD    3'h1
`define ZVS_OFF_DEAD      3'h2
`define ZVS_OFF_RESONANT_DELAY_PHASE    3'h3
`define ZVS_OFF_BLANK     3'h4
`define ZVS_OFF_STATUS    3'h5

// Field positions
`define ZVS_CTRL_BLANK_OFF 0
`define ZVS_ST_LATCHED     12
`define ZVS_ST_LOCKOUT     13
`define ZVS_ST_PGOOD       14
`define ZVS_ST_PGPIN       15

// Reset values
`define ZVS_RST_CTRL      1'b0
`define ZVS_RST_PERIOD    8'h64
`define ZVS_RST_DEAD      8'h0a
`define ZVS_RST_RESONANT_DELAY_PHASE    8'h0a
`define ZVS_RST_BLANK     8'h0a

// Timing: system clock period and programmable delays in picoseconds
`define ZVS_CLK_PS        5000
`define ZVS_RES_SLOPE_PS  4010
`define ZVS_RES_OFF_PS    13000
`define ZVS_LEB_SLOPE_PS  2000
`define ZVS_LEB_OFF_PS    15000

// Soft-start ramp: one count per step, microvolts per count
`define ZVS_SS_W          12
`define ZVS_SS_DIV        8'hc8
`define ZVS_SS_LSB_UV     1000
`define ZVS_SS_LEB_MV     400
`define ZVS_SS_LEB_CNT    ((`ZVS_SS_LEB_MV * 1000) / `ZVS_SS_LSB_UV)

// Synchronised comparator inputs
`define ZVS_NSYNC         7

`endif

// ### design/zvs_pkg.sv
package zvs_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RUN    = 2'b01,
        ST_LATCHD = 2'b10
    } zvs_state_e;
endpackage

// ### design/zvs_sync.sv
`timescale 1ns/1ps
`include "zvs_cfg.svh"

module zvs_sync (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Levels
    input  wire logic [`ZVS_NSYNC-1:0] d_in,
    output logic      [`ZVS_NSYNC-1:0] q_out
);
    logic [`ZVS_NSYNC-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

// ### design/zvs_pgood.sv
`timescale 1ns/1ps

module zvs_pgood (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Window comparator levels
    input  wire logic above_m3,
    input  wire logic above_m5,
    input  wire logic below_p3,
    input  wire logic below_p5,
    // Flag
    output logic      good
);
    logic good_next;

    // Enter above -3 and below +5 percent; leave below -5 or above +3 percent
    always_comb begin
        if (good)
            good_next = above_m5 && below_p3;
        else
            good_next = above_m3 && below_p5;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            good <= 1'b0;
        else
            good <= good_next;
    end

    a_pg_enter: assert property (@(posedge clk) disable iff (rst)
        !good && above_m3 && below_p5 |=> good)
        else $error("power good not entered");
endmodule

// ### testbench/zvs_bridge_model.sv
`timescale 1ns/1ps

module zvs_bridge_model (
    // Clock
    input  wire logic clk,
    // Gate drives from the controller
    input  wire logic hs_a,
    input  wire logic hs_b,
    input  wire logic ls_a,
    input  wire logic ls_b,
    // Current comparator and fault count
    input  int        trip_after,
    output logic      current_trip,
    output int        shoot_faults
);
    int on_cnt;

    initial begin
        current_trip = 1'b0;
        on_cnt = 0;
        shoot_faults = 0;
    end

    // Upper and lower switch of one leg conducting together is a shoot-through
    always @(posedge clk) begin
        if ((hs_a && ls_a) || (hs_b && ls_b)) shoot_faults++;
    end

    // Ramp crosses the error level after trip_after cycles; sense is zero while off
    always @(posedge clk) begin
        if (ls_a || ls_b) begin
            on_cnt++;
            current_trip <= (trip_after != 0) && (on_cnt >= trip_after);
        end else begin
            on_cnt = 0;
            current_trip <= 1'b0;
        end
    end
endmodule

// ### testbench/zvs_gate_sequencer_tb.sv
`timescale 1ns/1ps
`include "zvs_cfg.svh"

module zvs_gate_sequencer_tb;
    localparam int P = 20;
    localparam int D = 4;
    // Resonant delay cycles for the default 10 kohm setting, rounded up
    localparam int R = (`ZVS_RES_SLOPE_PS * 10 + `ZVS_RES_OFF_PS + `ZVS_CLK_PS - 1) / `ZVS_CLK_PS;

    logic        clk, rst, wr, rd, lockout, peak, latch, run, trip;
    logic        hs_a, hs_b, ls_a, ls_b, rc_a, rc_b, ramp, blank, pg_o, pg_oe;
    logic [2:0]  addr;
    logic [15:0] wdata, rdata, v;
    logic [3:0]  fb;
    logic [11:0] ss;
    logic [7:0]  cap [0:2*P-1];
    int          trip_after, shoot_faults, num_errors, comparisons;
    // Open-drain pin with pull-up
    wire  logic       pg_pin = pg_oe ? pg_o : 1'b1;
    wire  logic [5:0] gates = {rc_b, rc_a, ls_b, ls_a, hs_b, hs_a};
    logic [3:0]  pg_seq [0:6] = '{4'h3, 4'h7, 4'hf, 4'h7, 4'h3, 4'hf, 4'hc};
    logic        pg_exp [0:6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0] rst_tbl [0:7] = '{16'h0000, 16'h0064, 16'h000a, 16'h000a,
                                   16'h000a, 16'h0000, 16'h0000, 16'h0000};

    zvs_gate_sequencer DUT (
        .CLK_SYS            (clk),
        .RESET              (rst),
        .REG_ADDR           (addr),
        .REG_WDATA          (wdata),
        .REG_WR             (wr),
        .REG_RD             (rd),
        .REG_RDATA          (rdata),
        .SUPPLY_LOCKOUT     (lockout),
        .PEAK_LIMIT_SENSE   (peak),
        .LATCH_OFF_INPUT    (latch),
        .RUN_REQUEST        (run),
        .CURRENT_TRIP       (trip),
        .FB_ABOVE_M3        (fb[3]),
        .FB_ABOVE_M5        (fb[2]),
        .FB_BELOW_P3        (fb[1]),
        .FB_BELOW_P5        (fb[0]),
        .HIGH_SIDE_GATE_A   (hs_a),
        .HIGH_SIDE_GATE_B   (hs_b),
        .LOW_SIDE_GATE_A    (ls_a),
        .LOW_SIDE_GATE_B    (ls_b),
        .RECTIFIER_GATE_A   (rc_a),
        .RECTIFIER_GATE_B   (rc_b),
        .RAMP_RESET         (ramp),
        .EDGE_BLANKING      (blank),
        .SOFT_START_LEVEL   (ss),
        .POWER_GOOD_FLAG_I  (pg_pin),
        .POWER_GOOD_FLAG_O  (pg_o),
        .POWER_GOOD_FLAG_OE (pg_oe)
    );

    zvs_bridge_model bridge (
        .clk          (clk),
        .hs_a         (hs_a),
        .hs_b         (hs_b),
        .ls_a         (ls_a),
        .ls_b         (ls_b),
        .trip_after   (trip_after),
        .current_trip (trip),
        .shoot_faults (shoot_faults)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        num_errors++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string m);
        comparisons++;
        if (got !== exp) fail(m);
    endtask

    task automatic chk_cnt(input int got, input int exp, input string m);
        comparisons++;
        if (got != exp) fail(m);
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    task automatic wait_rise(input int b, input int limit);
        logic prev;
        prev = gates[b];
        for (int i = 0; i < limit; i++) begin
            @(negedge clk);
            if (gates[b] === 1'b1 && prev === 1'b0) return;
            prev = gates[b];
        end
        fail("gate never rose");
        give_verdict();
    endtask

    task automatic hold_off(input int n);
        repeat (n) begin
            @(negedge clk);
            chk_reg({10'h000, gates}, 16'h0000, "gates not low");
        end
        @(posedge clk);
    endtask

    function automatic int count_hi(input int b);
        int n;
        n = 0;
        for (int i = 0; i < 2 * P; i++) n += int'(cap[i][b] === 1'b1);
        return n;
    endfunction

    function automatic int first_hi(input int b);
        for (int i = 0; i < 2 * P; i++) if (cap[i][b] === 1'b1) return i;
        return -1;
    endfunction

    // Records two clock periods from the rise of upper gate A
    task automatic check_cycle(input bit tripped);
        int n;
        wait_rise(0, 4 * P);
        for (int i = 0; i < 2 * P; i++) begin
            if (i > 0) @(negedge clk);
            cap[i] = {blank, ramp, gates};
        end
        chk_cnt(count_hi(0), P, "upper A width");
        chk_cnt(first_hi(1), P, "upper B start");
        chk_cnt(count_hi(1), P, "upper B width");
        chk_cnt(count_hi(4), P - D, "rect A width");
        chk_cnt(count_hi(5), P - D, "rect B width");
        chk_cnt(first_hi(3), R, "lower B start");
        chk_cnt(first_hi(2), P + R, "lower A start");
        chk_cnt(count_hi(6), 2 * D, "ramp reset width");
        chk_reg({15'h0000, cap[P + R / 2][7]}, 16'h0001, "no blanking");
        n = count_hi(2);
        if (tripped) begin
            chk_cnt(int'(n > 0 && n < P - D - R), 1, "lower A not cut");
        end else begin
            chk_cnt(n, P - D - R, "lower A width");
            chk_reg({15'h0000, cap[P + R + 2][7]}, 16'h0000, "early blanking");
        end
    endtask

    initial begin
        num_errors = 0;
        comparisons = 0;
        trip_after = 0;
        rst = 1'b1;
        {wr, rd, lockout, peak, latch, run} = 6'h00;
        addr = 3'h0;
        wdata = 16'h0000;
        fb = 4'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            reg_rd(i[2:0], v);
            if (i != 5) chk_reg(v, rst_tbl[i], "reset value");
        end
        reg_wr(`ZVS_OFF_PERIOD, 16'(P));
        reg_wr(`ZVS_OFF_DEAD, 16'(D));
        reg_wr(3'h6, 16'hffff);
        reg_wr(`ZVS_OFF_CTRL, 16'h0001);
        reg_rd(`ZVS_OFF_CTRL, v);
        chk_reg(v, 16'h0001, "blank-off setting");
        reg_wr(`ZVS_OFF_CTRL, 16'h0000);
        reg_rd(3'h6, v);
        chk_reg(v, 16'h0000, "unmapped read");
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            fb <= pg_seq[i];
            repeat (6) @(posedge clk);
            reg_rd(`ZVS_OFF_STATUS, v);
            chk_reg(v & 16'hc000, {~pg_exp[i], pg_exp[i], 14'h0}, "power good");
        end
        @(posedge clk);
        lockout <= 1'b1;
        run <= 1'b1;
        hold_off(2 * P);
        reg_rd(`ZVS_OFF_STATUS, v);
        chk_reg(v & 16'h2000, 16'h2000, "lockout flag");
        lockout <= 1'b0;
        // Let the first two periods pass, the first possibly partial
        repeat (2 * P) @(posedge clk);
        check_cycle(1'b0);
        trip_after = 2;
        check_cycle(1'b1);
        trip_after = 0;
        repeat (400) @(posedge clk);
        chk_reg({15'h0, ss == 12'h000}, 16'h0000, "soft-start idle");
        wait_rise(0, 4 * P);
        @(posedge clk);
        peak <= 1'b1;
        hold_off(3);
        peak <= 1'b0;
        hold_off(P - 8);
        chk_reg({4'h0, ss}, 16'h0000, "soft-start kept");
        wait_rise(0, 4 * P);
        @(posedge clk);
        run <= 1'b0;
        repeat (5) @(posedge clk);
        hold_off(2 * P);
        chk_reg({4'h0, ss}, 16'h0000, "soft-start kept");
        run <= 1'b1;
        wait_rise(0, 4 * P);
        @(posedge clk);
        latch <= 1'b1;
        repeat (3) @(posedge clk);
        latch <= 1'b0;
        run <= 1'b0;
        repeat (5) @(posedge clk);
        run <= 1'b1;
        hold_off(3 * P);
        reg_rd(`ZVS_OFF_STATUS, v);
        chk_reg(v & 16'h1000, 16'h1000, "latch flag");
        lockout <= 1'b1;
        hold_off(3);
        lockout <= 1'b0;
        wait_rise(0, 5 * P);
        reg_rd(`ZVS_OFF_STATUS, v);
        chk_reg(v & 16'h3000, 16'h0000, "latch cleared");
        chk_cnt(shoot_faults, 0, "shoot-through");
        give_verdict();
    end
endmodule
